// ===== bmw_defs.svh
// constants for the bridge memory window decode block
`ifndef BMW_DEFS_SVH
`define BMW_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BMW_OFS_CMD 12'h004
`define BMW_OFS_CLS 12'h00c
`define BMW_OFS_MEM 12'h020
`define BMW_OFS_PF 12'h024
`define BMW_OFS_BCTL 12'h03c
`define BMW_OFS_LCNT 12'hfa0
`define BMW_OFS_PCNT 12'hfa4

// ----------------------------------------
// field positions
// ----------------------------------------
`define BMW_B_MEM_EN 1
`define BMW_B_BM_EN 2
`define BMW_B_SNOOP 5
`define BMW_B_VGA_EN 19
`define BMW_B_VGA16 20
`define BMW_B_LINE2 4
`define BMW_F_CLS 7:0
`define BMW_F_BASE 15:4
`define BMW_F_LIM 31:20
`define BMW_F_LOWZ 3:0
`define BMW_F_PCNT 13:8

// ----------------------------------------
// widths and values
// ----------------------------------------
`define BMW_WIN_W 12
`define BMW_LEN_W 13
`define BMW_RST_WIN 12'h000
`define BMW_RST_CLS 8'h00
`define BMW_RST_PCNT 6'h00
`define BMW_LINE_CAP 8'h80
`define BMW_PAL_A 10'h3c6
`define BMW_PAL_B 10'h3c8
`define BMW_PAL_C 10'h3c9
`define BMW_BUF_DEPTH 2

`endif

// ===== bmw_pkg.sv
// types shared by the bridge memory window decode block
`include "bmw_defs.svh"

package bmw_pkg;

  // ----------------------------------------
  // request and decision
  // ----------------------------------------
  typedef enum logic [1:0] {
    BMW_ACT_IGNORE,
    BMW_ACT_FWD,
    BMW_ACT_UR,
    BMW_ACT_DROP
  } bmw_act_t;

  typedef enum logic [1:0] {
    BMW_RD_PLAIN,
    BMW_RD_LINE,
    BMW_RD_MULT
  } bmw_rdk_t;

  typedef struct packed {
    logic [31:0] addr;
    logic dac;
    logic from_par;
    logic pcix;
    logic is_io;
    logic write;
    logic posted;
    bmw_rdk_t kind;
    logic [`BMW_LEN_W-1:0] len;
  } bmw_req_t;

  typedef struct packed {
    bmw_act_t act;
    logic palette;
    logic np_hit;
    logic p_hit;
    logic prefetch;
    logic [`BMW_LEN_W-1:0] size;
  } bmw_dec_t;

  // ----------------------------------------
  // state of the top module
  // ----------------------------------------
  typedef struct packed {
    logic [`BMW_WIN_W-1:0] mem_base;
    logic [`BMW_WIN_W-1:0] mem_lim;
    logic [`BMW_WIN_W-1:0] pf_base;
    logic [`BMW_WIN_W-1:0] pf_lim;
    logic mem_en;
    logic bm_en;
    logic snoop;
    logic vga_en;
    logic vga16;
    logic [7:0] cls;
    logic line2;
    logic [5:0] pf_cnt;
    logic [31:0] rdata;
    logic rack;
    logic pf_active;
    logic flush;
  } bmw_regs_t;

endpackage

// ===== bmw_window.sv
// base and limit compare for one memory window
`timescale 1ns/1ps

module bmw_window #(
  parameter int AW = 12
) (
  input wire logic [AW-1:0] base,
  input wire logic [AW-1:0] limit,
  input wire logic [AW-1:0] addr_hi,
  output logic enabled,
  output logic hit
);

  // ----------------------------------------
  // inclusive compare on 1 MB units
  // ----------------------------------------
  always_comb begin
    enabled = (base <= limit);
    hit = enabled && (addr_hi >= base) && (addr_hi <= limit);
  end

endmodule

// ===== bmw_buf.sv
// small valid/ready buffer in the decision path
`timescale 1ns/1ps

module bmw_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] d;
    logic [DEPTH-1:0] v;
    logic rdy;
  } bmw_buf_st_t;

  bmw_buf_st_t st_reg;
  bmw_buf_st_t st_next;

  // ----------------------------------------
  // shift toward the head, fill lowest free
  // ----------------------------------------
  always_comb begin
    logic push;
    logic pop;
    logic done;
    push = in_valid && st_reg.rdy;
    pop = st_reg.v[0] && out_ready;
    done = 1'b0;
    st_next = st_reg;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_next.d[i] = st_reg.d[i+1];
        st_next.v[i] = st_reg.v[i+1];
      end
      st_next.v[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!st_next.v[i] && !done) begin
          st_next.d[i] = in_data;
          st_next.v[i] = 1'b1;
          done = 1'b1;
        end
      end
    end
    st_next.rdy = !st_next.v[DEPTH-1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.d <= '0;
      st_reg.v <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = st_reg.rdy;
  assign out_valid = st_reg.v[0];
  assign out_data = st_reg.d[0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_buf_hold_head: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");

  a_buf_full_stall: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.v[DEPTH-1] |-> !in_ready)
    else $error("buffer accepts while full");

endmodule

// ===== bmw_decode.sv
// memory window, palette and prefetch decode for the bridge
`timescale 1ns/1ps
`include "bmw_defs.svh"

module bmw_decode
  import bmw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rev_mode,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rack,
  input wire logic req_valid,
  input wire bmw_req_t req,
  output logic req_ready,
  output logic dec_valid,
  output bmw_dec_t dec,
  input wire logic dec_ready,
  input wire logic rd_done,
  output logic pf_flush
);

  bmw_regs_t r_reg;
  bmw_regs_t r_next;
  bmw_dec_t d_next;
  logic push;
  logic np_en;
  logic np_in;
  logic p_en;
  logic p_in;
  logic [11:0] a_word;

  // ----------------------------------------
  // window compares
  // ----------------------------------------
  bmw_window #(
    .AW(`BMW_WIN_W)
  ) u_np_win (
    .base(r_reg.mem_base),
    .limit(r_reg.mem_lim),
    .addr_hi(req.addr[31:20]),
    .enabled(np_en),
    .hit(np_in)
  );

  bmw_window #(
    .AW(`BMW_WIN_W)
  ) u_p_win (
    .base(r_reg.pf_base),
    .limit(r_reg.pf_lim),
    .addr_hi(req.addr[31:20]),
    .enabled(p_en),
    .hit(p_in)
  );

  // ----------------------------------------
  // decision
  // ----------------------------------------
  always_comb begin
    logic prim;
    logic snoop_eff;
    logic pal_addr;
    logic hit;
    logic up_rd;
    logic [7:0] cap;
    hit = 1'b0;
    up_rd = 1'b0;
    cap = `BMW_RST_CLS;
    prim = rev_mode ? req.from_par : !req.from_par;
    snoop_eff = r_reg.snoop && rev_mode;
    pal_addr = (req.addr[9:0] == `BMW_PAL_A) ||
               (req.addr[9:0] == `BMW_PAL_B) ||
               (req.addr[9:0] == `BMW_PAL_C);
    d_next = '0;
    d_next.act = BMW_ACT_IGNORE;
    d_next.size = req.len;
    d_next.palette = req.is_io && prim && pal_addr &&
      (req.addr[31:16] == 16'h0000) &&
      (!r_reg.vga16 || (req.addr[15:10] == 6'h00));
    d_next.np_hit = !req.is_io && !req.dac && np_in;
    d_next.p_hit = !req.is_io && !req.dac && p_in;
    hit = d_next.np_hit || d_next.p_hit;
    if (req.is_io) begin
      if (d_next.palette && (r_reg.vga_en || (snoop_eff && req.write))) begin
        d_next.act = BMW_ACT_FWD;
      end
    end else if (prim) begin
      if (!r_reg.mem_en) begin
        if (rev_mode) begin
          d_next.act = BMW_ACT_IGNORE;
        end else begin
          d_next.act = req.posted ? BMW_ACT_DROP : BMW_ACT_UR;
        end
      end else begin
        d_next.act = hit ? BMW_ACT_FWD : BMW_ACT_IGNORE;
      end
    end else begin
      if (!r_reg.bm_en) begin
        if (rev_mode) begin
          d_next.act = req.posted ? BMW_ACT_DROP : BMW_ACT_UR;
        end else begin
          d_next.act = BMW_ACT_IGNORE;
        end
      end else begin
        d_next.act = hit ? BMW_ACT_IGNORE : BMW_ACT_FWD;
      end
    end
    up_rd = !req.is_io && req.from_par && !req.pcix && !req.write &&
            (d_next.act == BMW_ACT_FWD);
    cap = (r_reg.cls > `BMW_LINE_CAP) ? `BMW_LINE_CAP : r_reg.cls;
    if (up_rd && d_next.p_hit && !d_next.np_hit) begin
      d_next.prefetch = 1'b1;
      unique case (req.kind)
        BMW_RD_PLAIN: d_next.size = {7'h00, r_reg.pf_cnt};
        BMW_RD_LINE: d_next.size = {5'h00, r_reg.cls};
        BMW_RD_MULT: d_next.size = r_reg.line2 ?
          {4'h0, cap, 1'b0} : {5'h00, cap};
        default: d_next.size = req.len;
      endcase
    end else if (up_rd && req.kind != BMW_RD_PLAIN) begin
      d_next.prefetch = 1'b1;
      d_next.size = (req.kind == BMW_RD_MULT && r_reg.line2) ?
        {4'h0, r_reg.cls, 1'b0} : {5'h00, r_reg.cls};
    end
  end

  assign push = req_valid && req_ready;

  // ----------------------------------------
  // decision buffer
  // ----------------------------------------
  bmw_buf #(
    .W($bits(bmw_dec_t)),
    .DEPTH(`BMW_BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_data(d_next),
    .in_ready(req_ready),
    .out_valid(dec_valid),
    .out_data(dec),
    .out_ready(dec_ready)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_comb begin
    logic [31:0] cur;
    logic [31:0] wm;
    logic [31:0] w;
    wm = 32'h0000_0000;
    w = 32'h0000_0000;
    a_word = {cfg_addr[11:2], 2'b00};
    cur = 32'h0000_0000;
    unique case (a_word)
      `BMW_OFS_CMD: begin
        cur[`BMW_B_MEM_EN] = r_reg.mem_en;
        cur[`BMW_B_BM_EN] = r_reg.bm_en;
        cur[`BMW_B_SNOOP] = r_reg.snoop && rev_mode;
      end
      `BMW_OFS_CLS: cur[`BMW_F_CLS] = r_reg.cls;
      `BMW_OFS_MEM: begin
        cur[`BMW_F_BASE] = r_reg.mem_base;
        cur[`BMW_F_LIM] = r_reg.mem_lim;
      end
      `BMW_OFS_PF: begin
        cur[`BMW_F_BASE] = r_reg.pf_base;
        cur[`BMW_F_LIM] = r_reg.pf_lim;
      end
      `BMW_OFS_BCTL: begin
        cur[`BMW_B_VGA_EN] = r_reg.vga_en;
        cur[`BMW_B_VGA16] = r_reg.vga16;
      end
      `BMW_OFS_LCNT: cur[`BMW_B_LINE2] = r_reg.line2;
      `BMW_OFS_PCNT: cur[`BMW_F_PCNT] = r_reg.pf_cnt;
      default: cur = 32'h0000_0000;
    endcase
    wm = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    w = (cur & ~wm) | (cfg_wdata & wm);
    r_next = r_reg;
    r_next.rack = cfg_rd;
    r_next.rdata = cfg_rd ? cur : r_reg.rdata;
    if (cfg_wr) begin
      unique case (a_word)
        `BMW_OFS_CMD: begin
          r_next.mem_en = w[`BMW_B_MEM_EN];
          r_next.bm_en = w[`BMW_B_BM_EN];
          r_next.snoop = w[`BMW_B_SNOOP];
        end
        `BMW_OFS_CLS: r_next.cls = w[`BMW_F_CLS];
        `BMW_OFS_MEM: begin
          r_next.mem_base = w[`BMW_F_BASE];
          r_next.mem_lim = w[`BMW_F_LIM];
        end
        `BMW_OFS_PF: begin
          r_next.pf_base = w[`BMW_F_BASE];
          r_next.pf_lim = w[`BMW_F_LIM];
        end
        `BMW_OFS_BCTL: begin
          r_next.vga_en = w[`BMW_B_VGA_EN];
          r_next.vga16 = w[`BMW_B_VGA16];
        end
        `BMW_OFS_LCNT: r_next.line2 = w[`BMW_B_LINE2];
        `BMW_OFS_PCNT: r_next.pf_cnt = w[`BMW_F_PCNT];
        default: r_next.cls = r_reg.cls;
      endcase
    end
    // leftover prefetch flush; a new prefetch in the same cycle keeps pf_active set, though pf_flush still pulses
    r_next.flush = rd_done && r_reg.pf_active;
    if (r_next.flush) begin
      r_next.pf_active = 1'b0;
    end
    if (push && d_next.prefetch) begin
      r_next.pf_active = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.mem_base <= `BMW_RST_WIN;
      r_reg.mem_lim <= `BMW_RST_WIN;
      r_reg.pf_base <= `BMW_RST_WIN;
      r_reg.pf_lim <= `BMW_RST_WIN;
      r_reg.cls <= `BMW_RST_CLS;
      r_reg.pf_cnt <= `BMW_RST_PCNT;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cfg_rdata = r_reg.rdata;
  assign cfg_rack = r_reg.rack;
  assign pf_flush = r_reg.flush;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_snoop_fwd_zero: assert property (
    cfg_rd && a_word == `BMW_OFS_CMD && !rev_mode |=>
    cfg_rack && !cfg_rdata[`BMW_B_SNOOP])
    else $error("snoop bit visible in forward mode");

  a_pal_width_sel: assert property (
    d_next.palette && r_reg.vga16 |-> req.addr[15:10] == 6'h00)
    else $error("16-bit palette decode matched high alias");

  a_pal_addr_set: assert property (
    d_next.palette |-> req.addr[31:16] == 16'h0000 &&
    (req.addr[9:0] == `BMW_PAL_A || req.addr[9:0] == `BMW_PAL_B ||
     req.addr[9:0] == `BMW_PAL_C))
    else $error("palette decode on wrong address");

  a_pal_read_ignore: assert property (
    push && d_next.palette && !r_reg.vga_en && !req.write |->
    d_next.act == BMW_ACT_IGNORE)
    else $error("palette read claimed without vga enable");

  a_np_32bit_only: assert property (
    req.dac |-> !d_next.np_hit)
    else $error("64-bit address hit the non-prefetchable window");

  a_mem_en_ur: assert property (
    push && !req.is_io && !req.from_par && !rev_mode && !r_reg.mem_en
    && !req.posted |-> d_next.act == BMW_ACT_UR)
    else $error("non-posted request not answered with UR");

  a_bm_ignore_fwd: assert property (
    push && !req.is_io && req.from_par && !rev_mode && !r_reg.bm_en |->
    d_next.act == BMW_ACT_IGNORE)
    else $error("upstream memory forwarded with bus master off");

  a_base_low_zero: assert property (
    cfg_rd && a_word == `BMW_OFS_MEM |=> cfg_rdata[`BMW_F_LOWZ] == 4'h0)
    else $error("window low bits not zero");

  a_win_disabled: assert property (
    r_reg.mem_base > r_reg.mem_lim |-> !np_en && !d_next.np_hit)
    else $error("disabled window still hits");

  a_pf_win_off: assert property (
    r_reg.pf_base > r_reg.pf_lim |-> !p_en && !d_next.p_hit)
    else $error("disabled prefetchable window still hits");

  a_mult_cap: assert property (
    push && d_next.prefetch && d_next.p_hit && !d_next.np_hit &&
    req.kind == BMW_RD_MULT |-> d_next.size <= 13'h0100)
    else $error("multiple-line prefetch above cap");

  a_flush_pulse: assert property (
    rd_done && r_reg.pf_active && !(push && d_next.prefetch) |=>
    pf_flush && !r_reg.pf_active ##1 !pf_flush)
    else $error("leftover prefetch not flushed");

endmodule

// ===== bmw_sink.sv
// far-side consumer of the decision stream
`timescale 1ns/1ps

module bmw_sink
  import bmw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic dec_valid,
  input wire bmw_dec_t dec,
  output logic dec_ready,
  output logic got,
  output bmw_dec_t got_dec
);
  // ----------------------------------------
  // mode 0 prompt, 1 every other cycle, 2 stalled
  // ----------------------------------------
  logic tick_reg;

  assign dec_ready = (mode == 2'h0) || ((mode == 2'h1) && tick_reg);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_reg <= 1'b0;
      got <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
      got <= dec_valid && dec_ready;
    end
    got_dec <= dec;
  end
endmodule

// ===== bmw_decode_bench.sv
// self-checking bench for the memory window decode block
`timescale 1ns/1ps

module bmw_decode_bench
  import bmw_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, rev_mode = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, req_valid = 1'b0, rd_done = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [1:0] mode = 2'h0;
  bmw_req_t req = '0;
  logic [31:0] cfg_rdata;
  logic cfg_rack, req_ready, dec_valid, dec_ready, pf_flush, got;
  bmw_dec_t dec, got_dec;
  bmw_dec_t rxq[$];
  int err_count = 0, total_checks = 0, cyc = 0;
  localparam logic [5:0] lk_wr = 6'h03, lk_rd = 6'h00, pa_rd = 6'h10;
  localparam logic [5:0] pa_wr = 6'h13, io_wr = 6'h16, io_rd = 6'h14;
  localparam bmw_rdk_t pl = BMW_RD_PLAIN, ln = BMW_RD_LINE;
  localparam bmw_rdk_t ml = BMW_RD_MULT;
  localparam bmw_act_t fw = BMW_ACT_FWD, ig = BMW_ACT_IGNORE;
  localparam bmw_act_t ur = BMW_ACT_UR, dr = BMW_ACT_DROP;

  always #25 ref_clk = ~ref_clk;

  bmw_decode uut (
    .ref_clk(ref_clk), .rst(rst), .rev_mode(rev_mode),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rack(cfg_rack), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .dec_valid(dec_valid), .dec(dec),
    .dec_ready(dec_ready), .rd_done(rd_done), .pf_flush(pf_flush)
  );

  bmw_sink sink (
    .ref_clk(ref_clk), .rst(rst), .mode(mode), .dec_valid(dec_valid),
    .dec(dec), .dec_ready(dec_ready), .got(got), .got_dec(got_dec)
  );

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (got === 1'b1) begin
      rxq.push_back(got_dec);
    end
    if (cyc == 6000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cw(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hf);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic cr(input logic [11:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    cmp_word("cfg_rack", 32'h1, {31'h0, cfg_rack});
    cmp_word("cfg_rdata", e, cfg_rdata);
  endtask

  task automatic send(input logic [31:0] a, input logic [5:0] f,
                      input bmw_rdk_t k);
    int n = 0;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = {a, f, k, 13'h008};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask

  task automatic take(input bmw_act_t ea, output bmw_dec_t d);
    int n = 0;
    while (rxq.size() == 0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    d = '0;
    if (rxq.size() != 0) begin
      d = rxq.pop_front();
    end
    cmp_word("decision", 32'h1, {31'h0, n < 50});
    cmp_word("act", {30'h0, ea}, {30'h0, d.act});
  endtask

  task automatic go(input logic [31:0] a, input logic [5:0] f,
                    input bmw_rdk_t k, input bmw_act_t ea,
                    input logic [3:0] eh = 4'h0,
                    input logic [12:0] es = 13'h008);
    bmw_dec_t d;
    send(a, f, k);
    take(ea, d);
    if (eh[3] && f[2]) begin
      cmp_word("palette", {31'h0, eh[0]}, {31'h0, d.palette});
    end else if (eh[3]) begin
      cmp_word("flags", {29'h0, eh[2:0]},
               {29'h0, d.np_hit, d.p_hit, d.prefetch});
      cmp_word("size", {19'h0, es}, {19'h0, d.size});
    end
  endtask

  task automatic flush(input logic e);
    @(negedge ref_clk);
    rd_done = 1'b1;
    @(negedge ref_clk);
    rd_done = 1'b0;
    cmp_word("pf_flush", {31'h0, e}, {31'h0, pf_flush});
    @(negedge ref_clk);
    cmp_word("pf_flush", 32'h0, {31'h0, pf_flush});
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    bmw_dec_t d;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    cmp_word("req_ready", 32'h1, {31'h0, req_ready});
    cr(12'h020, 32'h0);
    cr(12'h004, 32'h0);
    cw(12'h020, 32'hffff_ffff);
    cr(12'h020, 32'hfff0_fff0);
    cw(12'h100, 32'hffff_ffff);
    cr(12'h100, 32'h0);
    cw(12'h020, 32'h1ff0_1000);
    cw(12'h020, 32'hffff_ffff, 4'h3);
    cr(12'h020, 32'h1ff0_fff0);
    cw(12'h020, 32'h1ff0_1000);
    cw(12'h024, 32'h4ff0_4000);
    cw(12'h004, 32'h0000_0006);
    cw(12'h00c, 32'h0000_0040);
    cw(12'hfa0, 32'h0000_0010);
    cw(12'hfa4, 32'h0000_2000);
    $display("test registers done");
    go(32'h1000_0000, lk_wr, pl, fw, 4'hc);
    go(32'h1fff_ffff, lk_wr, pl, fw, 4'hc);
    go(32'h2000_0000, lk_wr, pl, ig, 4'h8);
    go(32'h1000_0000, 6'h23, pl, ig, 4'h8);
    go(32'h3000_0000, pa_rd, ln, fw, 4'h9, 13'h040);
    flush(1'b1);
    flush(1'b0);
    go(32'h3000_0000, pa_rd, ml, fw, 4'h9, 13'h080);
    go(32'h3000_0000, pa_rd, pl, fw, 4'h8);
    go(32'h3000_0000, 6'h18, ln, fw, 4'h8);
    go(32'h1000_0000, lk_rd, ln, fw, 4'hc);
    go(32'h1000_0000, pa_rd, ln, ig, 4'hc);
    go(32'h4000_0000, pa_rd, pl, ig, 4'ha);
    $display("test forward decode done");
    mode = 2'h2;
    send(32'h1000_0000, lk_wr, pl);
    send(32'h2000_0000, lk_wr, pl);
    cmp_word("req_ready", 32'h0, {31'h0, req_ready});
    cmp_word("dec_valid", 32'h1, {31'h0, dec_valid});
    mode = 2'h1;
    send(32'h1000_0000, lk_wr, pl);
    take(fw, d);
    take(ig, d);
    take(fw, d);
    mode = 2'h0;
    $display("test buffer done");
    cw(12'h004, 32'h0000_0004);
    go(32'h1000_0000, lk_rd, pl, ur);
    go(32'h1000_0000, lk_wr, pl, dr);
    go(32'h4000_0000, lk_wr, pl, dr);
    cw(12'h004, 32'h0000_0002);
    go(32'h3000_0000, pa_rd, pl, ig);
    rev_mode = 1'b1;
    go(32'h3000_0000, lk_rd, pl, ur);
    go(32'h3000_0000, lk_wr, pl, dr);
    cw(12'h004, 32'h0000_0004);
    go(32'h1000_0000, pa_rd, pl, ig);
    go(32'h4000_0000, pa_rd, pl, ig);
    $display("test enables done");
    cw(12'h004, 32'h0000_0006);
    go(32'h1000_0000, pa_wr, pl, fw, 4'hc);
    go(32'h4000_0000, pa_rd, pl, fw, 4'hb, 13'h020);
    go(32'h4000_0000, pa_rd, ln, fw, 4'hb, 13'h040);
    cw(12'h00c, 32'h0000_00c0);
    go(32'h4000_0000, pa_rd, ml, fw, 4'hb, 13'h100);
    cw(12'hfa0, 32'h0000_0000);
    go(32'h4000_0000, pa_rd, ml, fw, 4'hb, 13'h080);
    go(32'h4000_0000, 6'h18, pl, fw, 4'ha);
    go(32'h3000_0000, lk_rd, pl, fw, 4'h8);
    cw(12'h020, 32'h1000_2000);
    go(32'h1500_0000, pa_wr, pl, ig, 4'h8);
    go(32'h4000_0000, pa_wr, pl, fw, 4'ha);
    cw(12'h024, 32'h3ff0_4000);
    go(32'h4000_0000, pa_wr, pl, ig, 4'h8);
    $display("test reverse windows done");
    cw(12'h004, 32'h0000_0026);
    cr(12'h004, 32'h0000_0026);
    go(32'h0000_03c6, io_wr, pl, fw, 4'h9);
    go(32'h0000_03c8, io_rd, pl, ig, 4'h9);
    go(32'h0000_03c9, io_wr, pl, fw, 4'h9);
    go(32'h0000_03c7, io_wr, pl, ig, 4'h8);
    go(32'h0000_13c6, io_wr, pl, fw, 4'h9);
    cw(12'h03c, 32'h0010_0000);
    go(32'h0000_13c6, io_wr, pl, ig, 4'h8);
    go(32'h0000_03c8, io_wr, pl, fw, 4'h9);
    go(32'h0001_03c6, io_wr, pl, ig, 4'h8);
    cw(12'h004, 32'h0000_0006);
    go(32'h0000_03c6, io_wr, pl, ig, 4'h9);
    cw(12'h03c, 32'h0008_0000);
    go(32'h0000_03c9, io_rd, pl, fw, 4'h9);
    go(32'h0000_03c6, 6'h06, pl, ig, 4'h8);
    cw(12'h004, 32'h0000_0026);
    rev_mode = 1'b0;
    cr(12'h004, 32'h0000_0006);
    go(32'h0000_03c9, 6'h04, pl, fw, 4'h9);
    cw(12'h03c, 32'h0000_0000);
    go(32'h0000_03c6, 6'h06, pl, ig, 4'h9);
    $display("test palette done");
    end_sim();
  end
endmodule
